// [nbi_consts.vh]
`ifndef NBI_CONSTS_VH
`define NBI_CONSTS_VH
// controller register map (word offsets on the plain port)
`define NBI_REG_CTRL      4'h0
`define NBI_REG_STATUS    4'h1
`define NBI_REG_CMD       4'h2
`define NBI_REG_ADDR_LO   4'h3
`define NBI_REG_ADDR_HI   4'h4
`define NBI_REG_WDATA     4'h5
`define NBI_REG_RDATA     4'h6
`define NBI_REG_COUNT     4'h7
`define NBI_REG_OP        4'h8
// ctrl fields
`define NBI_CTRL_TGT0     0
`define NBI_CTRL_TGT1     1
`define NBI_CTRL_WP       2
`define NBI_CTRL_EXT_OUT  3
`define NBI_CTRL_RESET    8'h00
// op codes written to the op register
`define NBI_OP_CMD        3'h1
`define NBI_OP_ADDR5      3'h2
`define NBI_OP_WRITE      3'h3
`define NBI_OP_READ       3'h4
`define NBI_OP_ADDR1      3'h5
// status fields
`define NBI_ST_BUSY       0
`define NBI_ST_READY      1
`define NBI_ST_RVALID     2
`define NBI_ST_WP_WAIT    3
// command codes accepted while busy
`define NBI_CMD_STATUS    8'h70
`define NBI_CMD_DIE_STAT  8'h78
// timing at 250 MHz, 4 ns period
`define NBI_CLK_NS        4
`define NBI_STROBE_NS     20
`define NBI_STROBE_CYC    ((`NBI_STROBE_NS + `NBI_CLK_NS - 1) / `NBI_CLK_NS)
`define NBI_SLOW_RC_NS    30
`define NBI_GUARD_NS      100
`define NBI_GUARD_CYC     ((`NBI_GUARD_NS + `NBI_CLK_NS - 1) / `NBI_CLK_NS)
// address layout
`define NBI_COL_LIMIT     13'h10e0
`define NBI_PLANE_BIT     7
`endif

// [nbi_dev.sv]
`default_nettype none
module nbi_dev #(
	parameter BUSY_NS = 3000
) (
	input  wire logic       select_n,
	input  wire logic       cmd_latch,
	input  wire logic       addr_latch,
	input  wire logic       write_strobe_n,
	input  wire logic       read_strobe_n,
	input  wire logic       protect_n,
	input  wire logic       io_oe_n,
	input  wire logic [7:0] io_out,
	output wire logic [7:0] io_in,
	output wire logic       ready_busy_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       busy = 1'b0;
	logic       drv  = 1'b0;
	logic [7:0] cmd  = 8'h00;
	logic [7:0] dout = 8'h00;
	logic [7:0] ab [0:4];
	logic [7:0] cache [0:7];
	int         na = 0;
	int         nd = 0;
	wire [7:0]  bus = io_oe_n ? (drv ? dout : ~dout) : io_out;
	wire        plane = ab[2][7];
	// asynchronous mode only: column bit 0 is stored as sent, never forced low
	assign io_in = bus;
	assign ready_busy_n = busy ? 1'b0 : 1'b1;
	// only target 0 lives here; a deselected target ignores strobes
	always @(posedge write_strobe_n) if (!select_n && read_strobe_n) begin
		if (cmd_latch && !addr_latch && (!busy || bus == 8'h70 || bus == 8'h78)) begin
			cmd = bus;
			na = 0;
			nd = 0;
			if (bus == 8'h10 && protect_n) begin
				busy = 1'b1;
				busy <= #(BUSY_NS) 1'b0;
			end
		end else if (addr_latch && !cmd_latch && (!busy || cmd == 8'h78) && na < 5) begin
			ab[na] = bus;
			na++;
		end else if (!cmd_latch && !addr_latch && !busy) begin
			cache[nd[2:0]] = bus;
			nd++;
		end
	end
	always @(negedge read_strobe_n) if (!select_n && write_strobe_n && !cmd_latch && !addr_latch) begin
		drv = 1'b1;
		if (cmd == 8'h70 || cmd == 8'h78) dout = {protect_n, ~busy, 6'h00};
		else if (!busy) begin
			dout = cache[nd[2:0]];
			nd++;
		end
	end
	// released bus shows the inverse of the last byte, not a stale copy
	always @(posedge select_n) drv = 1'b0;
endmodule // nbi_dev
`default_nettype wire

// [nbi_host.v]
`include "nbi_consts.vh"
`default_nettype none
// What this block does
// - each target driven only through its own select line
// - pausing data transfers holds the relevant strobe high
// - unused address bits driven low; cycle count matches command
// - five address cycles: column, column, page plus plane, block, block
// - column addresses 4320 to 8191 are never sent
// - fast cycles capture at the end of the high phase after read rise, slow on read rise
// - protect changes only when ready, then wait settle time
module nbi_host #(
	parameter GUARD_CYC = `NBI_GUARD_CYC
) (
	input  wire        clk,
	input  wire        srst,
	input  wire [3:0]  reg_addr,
	input  wire [31:0] reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [31:0] reg_rdata,
	output reg         select_n,
	output reg         second_target_select_n,
	output reg         cmd_latch,
	output reg         addr_latch,
	output reg         write_strobe_n,
	output reg         read_strobe_n,
	output reg         protect_n,
	output reg  [7:0]  io_out,
	input  wire [7:0]  io_in,
	output reg         io_oe_n,
	output wire        data_strobe_oe_n,
	input  wire        ready_busy_n
);
	localparam ST_IDLE = 3'd0;
	localparam ST_LOW  = 3'd1;
	localparam ST_HIGH = 3'd2;
	localparam ST_NEXT = 3'd3;
	localparam ST_SETL = 3'd4;

	reg [7:0]  ctrl;
	reg [7:0]  cmd;
	reg [31:0] addr_lo;
	reg [7:0]  addr_hi;
	reg [7:0]  wdata;
	reg [7:0]  rdata;
	reg        rvalid;
	reg [15:0] count;
	reg [2:0]  op;
	reg [2:0]  state;
	reg [2:0]  idx;
	reg [15:0] guard;
	wire       tick;
	wire       busy_pin = !ready_busy_n;
	// strobe width rounded up to whole cycles so no phase is shorter than the minimum
	localparam integer STROBE_CYC = `NBI_STROBE_CYC;
	wire [7:0] strobe_len = STROBE_CYC[7:0];

	assign data_strobe_oe_n = 1'b1;

	nbi_phase_timer #(.WIDTH(8)) u_timer (
		.clk       (clk),
		.srst      (srst),
		.run       (state == ST_LOW || state == ST_HIGH),
		.phase_len (strobe_len),
		.tick      (tick)
	);

	////////////////////////////////////////////////////////////////////////
	// byte of the five-cycle address, unused bits forced low
	function [7:0] addr_byte;
		input [2:0]  i;
		input [31:0] lo;
		input [7:0]  hi;
		begin
			case (i)
			3'd0: addr_byte = lo[7:0];
			3'd1: addr_byte = {3'b000, lo[12:8]};
			3'd2: addr_byte = lo[23:16];
			3'd3: addr_byte = lo[31:24];
			default: addr_byte = {5'b00000, hi[2:0]};
			endcase
		end
	endfunction

	// out-of-range columns are clamped to zero so they never reach the pins
	wire col_bad = addr_lo[12:0] >= `NBI_COL_LIMIT;
	wire [31:0] addr_use = col_bad ? {addr_lo[31:16], 16'h0000} : addr_lo;
	wire busy_ok = !busy_pin || cmd == `NBI_CMD_STATUS || cmd == `NBI_CMD_DIE_STAT;
	wire wp_change = reg_wr && reg_addr == `NBI_REG_CTRL && reg_wdata[`NBI_CTRL_WP] != ctrl[`NBI_CTRL_WP];

	////////////////////////////////////////////////////////////////////////
	always @(posedge clk) begin
		if (srst) begin
			ctrl    <= `NBI_CTRL_RESET;
			cmd     <= 8'h00;
			addr_lo <= 32'h00000000;
			addr_hi <= 8'h00;
			wdata   <= 8'h00;
			count   <= 16'h0000;
			op      <= 3'h0;
		end else if (reg_wr) begin
			case (reg_addr)
			`NBI_REG_CTRL: begin
				// protect may only move while ready and idle
				if (state == ST_IDLE && !busy_pin)
					ctrl <= reg_wdata[7:0];
				else
					ctrl <= {reg_wdata[7:3], ctrl[2], reg_wdata[1:0]};
			end
			`NBI_REG_CMD:     cmd <= reg_wdata[7:0];
			`NBI_REG_ADDR_LO: addr_lo <= reg_wdata;
			`NBI_REG_ADDR_HI: addr_hi <= reg_wdata[7:0];
			`NBI_REG_WDATA:   wdata <= reg_wdata[7:0];
			`NBI_REG_COUNT:   count <= reg_wdata[15:0];
			`NBI_REG_OP:      op <= reg_wdata[2:0];
			default: ;
			endcase
		end
	end

	always @(posedge clk) begin
		if (srst)
			reg_rdata <= 32'h00000000;
		else if (reg_rd) begin
			case (reg_addr)
			`NBI_REG_CTRL:    reg_rdata <= {24'h000000, ctrl};
			`NBI_REG_STATUS:  reg_rdata <= {28'h0000000, guard != 16'h0000, rvalid, ready_busy_n,
						state != ST_IDLE};
			`NBI_REG_CMD:     reg_rdata <= {24'h000000, cmd};
			`NBI_REG_ADDR_LO: reg_rdata <= addr_lo;
			`NBI_REG_ADDR_HI: reg_rdata <= {24'h000000, addr_hi};
			`NBI_REG_RDATA:   reg_rdata <= {24'h000000, rdata};
			`NBI_REG_COUNT:   reg_rdata <= {16'h0000, count};
			default:          reg_rdata <= 32'h00000000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// bus sequencer; every phase is held at least one strobe width
	always @(posedge clk) begin
		if (srst) begin
			state          <= ST_IDLE;
			idx            <= 3'd0;
			guard          <= 16'h0000;
			select_n       <= 1'b1;
			second_target_select_n <= 1'b1;
			cmd_latch      <= 1'b0;
			addr_latch     <= 1'b0;
			write_strobe_n <= 1'b1;
			read_strobe_n  <= 1'b1;
			protect_n      <= 1'b0;
			io_out         <= 8'h00;
			io_oe_n        <= 1'b1;
			rdata          <= 8'h00;
			rvalid         <= 1'b0;
		end else begin
			protect_n <= ctrl[`NBI_CTRL_WP];
			if (wp_change && state == ST_IDLE && !busy_pin)
				guard <= GUARD_CYC[15:0];
			else if (guard != 16'h0000)
				guard <= guard - 16'h0001;
			if (reg_rd && reg_addr == `NBI_REG_RDATA)
				rvalid <= 1'b0;
			case (state)
			ST_IDLE: begin
				// idle bus: select held high until an op starts, both strobes high
				write_strobe_n <= 1'b1;
				read_strobe_n  <= 1'b1;
				cmd_latch      <= 1'b0;
				addr_latch     <= 1'b0;
				io_oe_n        <= 1'b1;
				idx            <= 3'd0;
				if (reg_wr && reg_addr == `NBI_REG_OP && guard == 16'h0000) begin
					select_n <= !ctrl[`NBI_CTRL_TGT0];
					second_target_select_n <= !ctrl[`NBI_CTRL_TGT1] || ctrl[`NBI_CTRL_TGT0];
					state <= ST_SETL;
				end else begin
					select_n <= 1'b1;
					second_target_select_n <= 1'b1;
				end
			end
			ST_SETL: begin
				// only one qualifier at a time, so no invalid mix reaches the pins
				cmd_latch  <= (op == `NBI_OP_CMD);
				addr_latch <= (op == `NBI_OP_ADDR5 || op == `NBI_OP_ADDR1);
				io_oe_n    <= (op == `NBI_OP_READ);
				if (op == `NBI_OP_CMD)
					io_out <= cmd;
				else if (op == `NBI_OP_WRITE)
					io_out <= wdata;
				else
					io_out <= addr_byte(idx, addr_use, addr_hi);
				if (op == `NBI_OP_READ && !busy_ok)
					state <= ST_IDLE;
				else if ((op == `NBI_OP_ADDR5 || op == `NBI_OP_ADDR1 || op == `NBI_OP_WRITE)
						&& busy_pin && cmd != `NBI_CMD_DIE_STAT)
					state <= ST_IDLE;
				else if (op == `NBI_OP_CMD && busy_pin && !busy_ok)
					state <= ST_IDLE;
				else if (op < `NBI_OP_CMD || op > `NBI_OP_ADDR1)
					state <= ST_IDLE;
				else begin
					// strobe falls as the phase timer starts, so the low phase spans a full strobe width
					// never both strobes low
					if (op == `NBI_OP_READ)
						read_strobe_n <= 1'b0;
					else
						write_strobe_n <= 1'b0;
					state <= ST_LOW;
				end
			end
			ST_LOW: begin
				if (tick) begin
					// slow timing samples just before the rising edge
					if (op == `NBI_OP_READ && !ctrl[`NBI_CTRL_EXT_OUT]) begin
						rdata  <= io_in;
						rvalid <= 1'b1;
					end
					write_strobe_n <= 1'b1;
					read_strobe_n  <= 1'b1;
					state <= ST_HIGH;
				end
			end
			ST_HIGH: begin
				// strobe high pauses the transfer between bytes
				if (tick) begin
					if (op == `NBI_OP_READ && ctrl[`NBI_CTRL_EXT_OUT]) begin
						rdata  <= io_in;
						rvalid <= 1'b1;
					end
					state <= ST_NEXT;
				end
			end
			ST_NEXT: begin
				if (op == `NBI_OP_ADDR5 && idx != 3'd4) begin
					idx   <= idx + 3'd1;
					state <= ST_SETL;
				end else
					state <= ST_IDLE;
			end
			default: state <= ST_IDLE;
			endcase
		end
	end
endmodule // nbi_host
`default_nettype wire

// [nbi_host_props.sv]
`default_nettype none
module nbi_props #(
	parameter GUARD_CYC = 25
) (
	input wire logic       clk,
	input wire logic       srst,
	input wire logic       select_n,
	input wire logic       second_target_select_n,
	input wire logic       cmd_latch,
	input wire logic       addr_latch,
	input wire logic       write_strobe_n,
	input wire logic       read_strobe_n,
	input wire logic       protect_n,
	input wire logic [7:0] io_out,
	input wire logic       io_oe_n,
	input wire logic       data_strobe_oe_n,
	input wire logic       ready_busy_n
);
	timeunit 1ns;
	timeprecision 1ps;
	// cycles since the last protect change, parked at ff when long settled
	logic [7:0] gap;
	always @(posedge clk)
		if (srst) gap <= 8'hff;
		else if ($changed(protect_n)) gap <= 8'h00;
		else if (gap != 8'hff) gap <= gap + 8'h01;
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	////////////////////////////////////////////////////////////
	a_strobe_excl: assert property (write_strobe_n || read_strobe_n)
		else $error("both strobes low");
	a_latch_excl: assert property (!(cmd_latch && addr_latch))
		else $error("both latches high");
	a_dstrobe_idle: assert property (data_strobe_oe_n)
		else $error("data strobe driven");
	a_wr_width: assert property ($fell(write_strobe_n) |-> !write_strobe_n [*5] ##1 write_strobe_n)
		else $error("write strobe width");
	a_wr_setup: assert property (!write_strobe_n |-> read_strobe_n && !io_oe_n &&
		(!select_n || !second_target_select_n)) else $error("write cycle qualifiers");
	a_wr_hold: assert property (!write_strobe_n |=> $stable(io_out) && $stable(cmd_latch) &&
		$stable(addr_latch) && $stable(select_n)) else $error("bus moved under write strobe");
	a_rd_width: assert property ($fell(read_strobe_n) |-> !read_strobe_n [*5] ##1 read_strobe_n)
		else $error("read strobe width");
	a_rd_release: assert property (!read_strobe_n |-> io_oe_n && !cmd_latch && !addr_latch)
		else $error("read cycle qualifiers");
	a_wp_ready: assert property ($changed(protect_n) |-> $past(ready_busy_n))
		else $error("protect moved while busy");
	a_wp_settle: assert property ($fell(write_strobe_n) |-> gap >= GUARD_CYC)
		else $error("protect settle too short");
endmodule // nbi_props
`default_nettype wire

// [nbi_host_tb.sv]
`include "nbi_consts.vh"
`default_nettype none
module nbi_host_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int GC = 2;
	logic        clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [3:0]  reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0, s;
	wire  [31:0] reg_rdata;
	wire  [7:0]  io_out, io_in;
	wire         select_n, second_target_select_n, cmd_latch, addr_latch, write_strobe_n;
	wire         read_strobe_n, protect_n, io_oe_n, data_strobe_oe_n, ready_busy_n;
	int          n_fail = 0, n_compared = 0, cyc = 0;
	logic [31:0] al [2] = '{32'h9ac5f0df, 32'h000010e0};
	logic [39:0] ex [2] = '{40'hdf10c59a07, 40'h0000000007};
	nbi_host #(.GUARD_CYC(GC)) i_nbi_host (.*);
	nbi_dev i_nbi_dev (.*);
	initial forever #2 clk = ~clk;
	////////////////////////////////////////////////////////////
	task automatic final_report();
		if (n_fail == 0 && n_compared > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			final_report();
		end
	end
	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 s = reg_rdata;
	endtask
	// start an op, then poll until the sequencer is idle again
	task automatic op(input logic [31:0] code);
		wr(`NBI_REG_OP, code);
		for (int k = 0; k < 50; k++) begin
			rd(`NBI_REG_STATUS);
			if (s[`NBI_ST_BUSY] === 1'b0) break;
		end
	endtask
	task automatic cmd(input logic [7:0] c);
		wr(`NBI_REG_CMD, {24'h0, c});
		op(`NBI_OP_CMD);
	endtask
	////////////////////////////////////////////////////////////
	initial begin
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		rd(`NBI_REG_CTRL);
		chk(s, 32'h0);
		chk({select_n, second_target_select_n, write_strobe_n, read_strobe_n, protect_n}, 5'h1e);
		wr(`NBI_REG_CTRL, 32'h1);
		for (int i = 0; i < 2; i++) begin
			cmd(8'h05);
			chk(i_nbi_dev.cmd, 8'h05);
			wr(`NBI_REG_ADDR_LO, al[i]);
			wr(`NBI_REG_ADDR_HI, 32'hff);
			op(`NBI_OP_ADDR5);
			chk({i_nbi_dev.ab[0], i_nbi_dev.ab[1], i_nbi_dev.ab[2], i_nbi_dev.ab[3], i_nbi_dev.ab[4]}, ex[i]);
			chk(i_nbi_dev.plane, i == 0);
		end
		wr(`NBI_REG_WDATA, 32'ha5);
		op(`NBI_OP_WRITE);
		wr(`NBI_REG_WDATA, 32'h3c);
		op(`NBI_OP_WRITE);
		chk({i_nbi_dev.cache[0], i_nbi_dev.cache[1]}, 16'ha53c);
		cmd(8'h10);
		chk(ready_busy_n, 1'b1);
		wr(`NBI_REG_CTRL, 32'h5);
		// the sequencer drops ops until the protect settle count expires
		repeat (GC + 1) @(posedge clk);
		cmd(8'h10);
		chk(ready_busy_n, 1'b0);
		rd(`NBI_REG_STATUS);
		chk(s[`NBI_ST_READY], 1'b0);
		wr(`NBI_REG_CTRL, 32'h1);
		repeat (2) @(posedge clk);
		#1 chk(protect_n, 1'b1);
		cmd(8'h00);
		chk(i_nbi_dev.cmd, 8'h10);
		cmd(8'h70);
		chk(i_nbi_dev.cmd, 8'h70);
		op(`NBI_OP_READ);
		rd(`NBI_REG_RDATA);
		chk(s[7:0], 8'h80);
		cmd(8'h78);
		wr(`NBI_REG_ADDR_LO, 32'h3);
		op(`NBI_OP_ADDR1);
		chk(i_nbi_dev.ab[0], 8'h03);
		for (int k = 0; k < 1000; k++) begin
			rd(`NBI_REG_STATUS);
			if (s[`NBI_ST_READY] === 1'b1) break;
		end
		chk(s[`NBI_ST_READY], 1'b1);
		cmd(8'h00);
		op(`NBI_OP_READ);
		rd(`NBI_REG_RDATA);
		chk(s[7:0], 8'ha5);
		wr(`NBI_REG_CTRL, 32'hd);
		op(`NBI_OP_READ);
		rd(`NBI_REG_RDATA);
		chk(s[7:0], 8'h3c);
		wr(`NBI_REG_CTRL, 32'he);
		cmd(8'hee);
		chk(i_nbi_dev.cmd, 8'h00);
		final_report();
	end
endmodule // nbi_host_tb
bind nbi_host nbi_props #(.GUARD_CYC(GUARD_CYC)) i_nbi_props (.*);
`default_nettype wire

// [nbi_phase_timer.v]
`default_nettype none
// one-cycle tick every phase_len cycles while run is high
module nbi_phase_timer #(
	parameter WIDTH = 8
) (
	input  wire             clk,
	input  wire             srst,
	input  wire             run,
	input  wire [WIDTH-1:0] phase_len,
	output wire             tick
);
	reg [WIDTH-1:0] count;
	assign tick = run && (count == phase_len - {{(WIDTH-1){1'b0}}, 1'b1});
	always @(posedge clk) begin
		if (srst || !run || tick)
			count <= {WIDTH{1'b0}};
		else
			count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
	end
endmodule // nbi_phase_timer
`default_nettype wire
